/* saos_supervisor.sv */
// Stall prevention and over-torque supervisor top
`timescale 1ns/1ps
`default_nettype none
module saos_supervisor
    import saos_pkg::*;
#(
    parameter int unsigned UNIT_CYC = UNIT_CYC_NOM
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Settings
    input wire saos_cfg_t cfg,
    // Measurements
    input wire saos_meas_t meas,
    // Drive command
    input wire logic run_cmd,
    input wire logic [FREQ_W-1:0] cmd_freq,
    input wire logic [15:0] accel_time,
    input wire logic [15:0] decel_time,
    input wire logic fault_clear,
    // Status
    output var saos_stat_t status_ff
);
    saos_state_t state_ff;
    saos_state_t nxt_state;
    logic [FREQ_W-1:0] freq_ff;
    logic [FREQ_W-1:0] nxt_freq;
    logic [1:0] fault_ff;
    logic reached_ff;
    logic [FREQ_W-1:0] target;
    logic [FREQ_W-1:0] comp_now;
    logic [31:0] slip_prod;
    logic running;
    logic over_up;
    logic over_cs;
    logic over_dn;
    logic over_ot;
    logic over_rated;
    logic ov_hold;
    logic hold_up;
    logic hold_dn;
    logic ot_en;
    logic ot_alarm;
    logic ot_trip;
    logic stop_trip;
    logic trip;
    logic acc_pulse;
    logic dec_pulse;
    logic stall_pulse;

    // Current above a percent level of rated current; zero level never fires
    function automatic logic exceeds(
        input logic [15:0] cur,
        input logic [7:0] lvl,
        input logic [15:0] rated
    );
        logic [31:0] lhs;
        logic [31:0] rhs;
        lhs = 32'(cur) * PCT_FULL;
        rhs = 32'(lvl) * 32'(rated);
        return (lvl != 8'h00) && (lhs > rhs);
    endfunction

    assign target = run_cmd ? cmd_freq : '0;
    assign running = (state_ff != ST_IDLE) && (state_ff != ST_FAULT);

    assign over_up = exceeds(meas.output_current, cfg.rampup_stall_level,
                             cfg.rated_motor_current);
    assign over_cs = exceeds(meas.output_current, cfg.constant_speed_stall_level,
                             cfg.rated_motor_current);
    assign over_dn = exceeds(meas.output_current, cfg.decel_stall_level,
                             cfg.rated_motor_current);
    assign over_ot = exceeds(meas.output_current, cfg.overtorque_detect_level,
                             cfg.rated_motor_current);
    assign over_rated = meas.output_current > cfg.rated_motor_current;

    assign ov_hold = cfg.ov_stall_enable && (meas.dc_bus_voltage > meas.ov_threshold);
    assign hold_up = over_up;
    assign hold_dn = ov_hold || over_dn;

    // Modes 0/1 wait for target reached, 2/3 watch throughout running
    assign ot_en = running && (cfg.overtorque_detect_level != 8'h00) &&
                   (cfg.overtorque_detect_mode[1] || reached_ff);
    // Odd modes stop once the alarm point is passed
    assign stop_trip = ot_alarm && cfg.overtorque_detect_mode[0];
    assign trip = running && (over_rated || ot_trip || stop_trip);

    saos_rate_div u_acc_div (
        .clk(clk),
        .rst_n(rst_n),
        .run(state_ff == ST_ACCEL),
        .units(accel_time),
        .pulse_ff(acc_pulse)
    );

    saos_rate_div u_dec_div (
        .clk(clk),
        .rst_n(rst_n),
        .run(state_ff == ST_DECEL),
        .units(decel_time),
        .pulse_ff(dec_pulse)
    );

    saos_rate_div u_stall_div (
        .clk(clk),
        .rst_n(rst_n),
        .run(state_ff == ST_STALL),
        .units({8'h00, cfg.stall_decel_time}),
        .pulse_ff(stall_pulse)
    );

    saos_ot_timer #(
        .UNIT_CYC(UNIT_CYC)
    ) u_ot (
        .clk(clk),
        .rst_n(rst_n),
        .detect_en(ot_en),
        .over(over_ot),
        .detect_time(cfg.overtorque_detect_time),
        .alarm_ff(ot_alarm),
        .trip_ff(ot_trip)
    );

    always_comb
    begin
        nxt_state = state_ff;
        nxt_freq = freq_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (target != '0)
                    nxt_state = ST_ACCEL;
            end
            ST_ACCEL:
            begin
                if (freq_ff > target)
                    nxt_state = ST_DECEL;
                else if (freq_ff == target)
                    nxt_state = (target == '0) ? ST_IDLE : ST_CONST;
                else if (!hold_up && acc_pulse)
                    nxt_freq = freq_ff + 16'h0001;
            end
            ST_CONST:
            begin
                if (freq_ff > target)
                    nxt_state = ST_DECEL;
                else if (freq_ff < target)
                    nxt_state = ST_ACCEL;
                else if (target == '0)
                    nxt_state = ST_IDLE;
                else if (over_cs)
                    nxt_state = ST_STALL;
            end
            ST_STALL:
            begin
                if (!over_cs)
                    nxt_state = ST_ACCEL;
                else if (stall_pulse && freq_ff != '0)
                    nxt_freq = freq_ff - 16'h0001;
            end
            ST_DECEL:
            begin
                if (freq_ff <= target)
                    nxt_state = (freq_ff == '0) ? ST_IDLE : ST_CONST;
                else if (!hold_dn && dec_pulse)
                    nxt_freq = freq_ff - 16'h0001;
            end
            ST_FAULT:
            begin
                nxt_freq = '0;
                if (fault_clear && !run_cmd)
                    nxt_state = ST_IDLE;
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_freq = '0;
            end
        endcase
        if (trip)
        begin
            nxt_state = ST_FAULT;
            nxt_freq = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            freq_ff <= '0;
        else
            freq_ff <= nxt_freq;
    end

    // Target reached once; kept through stall dips until stop
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reached_ff <= 1'b0;
        else if (!running)
            reached_ff <= 1'b0;
        else if (state_ff == ST_CONST)
            reached_ff <= 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fault_ff <= FLT_NONE;
        else if (trip)
            fault_ff <= over_rated ? FLT_OVERCUR : FLT_OVERTORQUE;
        else if (state_ff == ST_FAULT && nxt_state == ST_IDLE)
            fault_ff <= FLT_NONE;
    end

    // Slip correction of gain/10000 of the frequency, a tenth at gain 1000
    assign slip_prod = 32'(freq_ff) * 32'(cfg.slip_compensation_gain);
    assign comp_now = freq_ff + 16'(slip_prod / SLIP_DIV);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            status_ff <= '0;
        else
        begin
            status_ff.freq <= freq_ff;
            status_ff.comp_freq <= comp_now;
            status_ff.drive_en <= running;
            status_ff.stall_active <= (state_ff == ST_STALL) ||
                                      (state_ff == ST_ACCEL && hold_up) ||
                                      (state_ff == ST_DECEL && hold_dn);
            status_ff.ot_alarm <= ot_alarm;
            status_ff.fault <= fault_ff;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_cs_over;
        state_ff == ST_CONST && freq_ff == target && target != '0 && over_cs && !trip;
    endsequence

    sequence s_stall_clear;
        state_ff == ST_STALL && !over_cs && !trip;
    endsequence

    AST_ACCEL_HOLD: assert property (state_ff == ST_ACCEL && freq_ff < target && over_up && !trip
        |=> freq_ff == $past(freq_ff))
        else $error("frequency rose during ramp-up stall");
    AST_ACCEL_STEP: assert property (state_ff == ST_ACCEL && freq_ff < target && !over_up && acc_pulse && !trip
        |=> freq_ff == $past(freq_ff) + 16'h0001)
        else $error("acceleration did not resume");
    AST_ZERO_LEVEL: assert property (cfg.rampup_stall_level == 8'h00 && state_ff == ST_ACCEL && freq_ff < target
        && acc_pulse && !trip |=> freq_ff == $past(freq_ff) + 16'h0001)
        else $error("zero ramp-up level still active");
    AST_SCALE: assert property (over_up |-> 32'(meas.output_current) * PCT_FULL >
        32'(cfg.rampup_stall_level) * 32'(cfg.rated_motor_current))
        else $error("level not scaled to rated current");
    AST_CS_STALL: assert property (s_cs_over |=> state_ff == ST_STALL)
        else $error("constant-speed stall not entered");
    AST_CS_RECOVER: assert property (s_stall_clear |=> state_ff == ST_ACCEL)
        else $error("no return to acceleration after stall");
    AST_STALL_RATE: assert property (state_ff == ST_STALL && !stall_pulse && !trip
        |=> freq_ff == $past(freq_ff))
        else $error("stall drop not paced by its divider");
    AST_OV_HOLD: assert property (state_ff == ST_DECEL && freq_ff > target && ov_hold && !trip
        |=> freq_ff == $past(freq_ff))
        else $error("deceleration continued above bus threshold");
    AST_STOP_MODE: assert property (running && ot_alarm && cfg.overtorque_detect_mode[0]
        |=> state_ff == ST_FAULT ##1 status_ff.drive_en == 1'b0)
        else $error("stop mode kept running");
    AST_EARLY_OT: assert property (cfg.overtorque_detect_mode[1] == 1'b0 && !reached_ff |-> !ot_en)
        else $error("at-speed modes detecting before target");
    AST_OT_OFF: assert property (cfg.overtorque_detect_level == 8'h00 |-> !ot_en)
        else $error("zero over-torque level still detecting");
    AST_OC_TRIP: assert property (running && over_rated
        |=> state_ff == ST_FAULT && freq_ff == '0 ##1 status_ff.fault == FLT_OVERCUR)
        else $error("overcurrent did not trip");
    AST_SLIP: assert property (1'b1 |=> status_ff.comp_freq >= $past(freq_ff))
        else $error("slip correction below base frequency");
    AST_OV_DEFAULT: assert property (state_ff == ST_DECEL && freq_ff > target && !cfg.ov_stall_enable && !over_dn
        && dec_pulse && !trip |=> freq_ff == $past(freq_ff) - 16'h0001)
        else $error("over-voltage hold while disabled");
endmodule
`default_nettype wire

/* saos_pkg.sv */
// Constants and types for the stall and over-torque supervisor
// What this block does
// - Hold acceleration while current above ramp-up level
// - Resume acceleration once current falls below
// - Zero stall level disables that check
// - Percent levels scale to rated motor current
// - Constant-speed overcurrent lowers output frequency
// - After recovery ramp back to command
// - Stall frequency drop paced by stall_decel_time
// - Over-voltage holds deceleration while bus high
// - Modes 0,1 detect at speed; 1 stops
// - Modes 2,3 detect always; 3 stops
// - Zero over-torque level disables detection
// - Over threshold starts over-torque time count
// - Past half detect time raise alarm
// - Past full detect time trip and stop
// - Current above rated current trips drive
// - Slip gain 0-1000 maps to 0-10%
// - Over-voltage stall enable bit, default on
package saos_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned OT_UNIT_MS = 100;
    localparam int unsigned UNIT_CYC_NOM = OT_UNIT_MS * (CLK_HZ / 1000);
    localparam int unsigned FREQ_W = 16;
    localparam int unsigned FREQ_FULL = 40000;
    localparam int unsigned RAMP_BASE_CYC = UNIT_CYC_NOM / FREQ_FULL;
    localparam logic [31:0] PCT_FULL = 32'h0000_0064;
    localparam logic [31:0] SLIP_DIV = 32'h0000_2710;
    localparam logic [1:0] FLT_NONE = 2'h0;
    localparam logic [1:0] FLT_OVERTORQUE = 2'h1;
    localparam logic [1:0] FLT_OVERCUR = 2'h2;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ACCEL = 6'b000010,
        ST_CONST = 6'b000100,
        ST_STALL = 6'b001000,
        ST_DECEL = 6'b010000,
        ST_FAULT = 6'b100000
    } saos_state_t;

    typedef struct packed {
        logic [7:0] rampup_stall_level;
        logic [7:0] constant_speed_stall_level;
        logic [7:0] decel_stall_level;
        logic [1:0] overtorque_detect_mode;
        logic [7:0] overtorque_detect_level;
        logic [7:0] overtorque_detect_time;
        logic [7:0] stall_decel_time;
        logic [15:0] rated_motor_current;
        logic [9:0] slip_compensation_gain;
        logic ov_stall_enable;
    } saos_cfg_t;

    typedef struct packed {
        logic [15:0] output_current;
        logic [15:0] dc_bus_voltage;
        logic [15:0] ov_threshold;
    } saos_meas_t;

    typedef struct packed {
        logic [FREQ_W-1:0] freq;
        logic [FREQ_W-1:0] comp_freq;
        logic drive_en;
        logic stall_active;
        logic ot_alarm;
        logic [1:0] fault;
    } saos_stat_t;

    // Factory settings of the configuration
    localparam saos_cfg_t CFG_DEFAULT = '{
        rampup_stall_level: 8'h96,
        constant_speed_stall_level: 8'h00,
        decel_stall_level: 8'h00,
        overtorque_detect_mode: 2'h0,
        overtorque_detect_level: 8'h00,
        overtorque_detect_time: 8'h0A,
        stall_decel_time: 8'h32,
        rated_motor_current: 16'h0000,
        slip_compensation_gain: 10'h000,
        ov_stall_enable: 1'b1
    };
endpackage

/* saos_rate_div.sv */
// Ramp step pulse generator: one pulse per units x base cycles
`timescale 1ns/1ps
`default_nettype none
module saos_rate_div
    import saos_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic [15:0] units,
    // Step enable
    output logic pulse_ff
);
    localparam int unsigned BW = $clog2(RAMP_BASE_CYC + 1);

    logic [BW-1:0] base_ff;
    logic [15:0] unit_ff;
    logic base_end;
    logic [15:0] unit_last;

    assign base_end = (base_ff == BW'(RAMP_BASE_CYC - 1));
    // Zero units still steps at the base rate
    assign unit_last = (units == 16'h0000) ? 16'h0000 : units - 16'h0001;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            base_ff <= '0;
        else if (!run || base_end)
            base_ff <= '0;
        else
            base_ff <= base_ff + BW'(1);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            unit_ff <= 16'h0000;
        else if (!run)
            unit_ff <= 16'h0000;
        else if (base_end)
            unit_ff <= (unit_ff >= unit_last) ? 16'h0000 : unit_ff + 16'h0001;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pulse_ff <= 1'b0;
        else
            pulse_ff <= run && base_end && (unit_ff >= unit_last);
    end
endmodule
`default_nettype wire

/* saos_ot_timer.sv */
// Over-torque episode timer with alarm and trip
`timescale 1ns/1ps
`default_nettype none
module saos_ot_timer
    import saos_pkg::*;
#(
    parameter int unsigned UNIT_CYC = UNIT_CYC_NOM
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Detection inputs
    input wire logic detect_en,
    input wire logic over,
    input wire logic [7:0] detect_time,
    // Results
    output logic alarm_ff,
    output logic trip_ff
);
    localparam int unsigned SW = $clog2(UNIT_CYC + 1);

    logic [SW-1:0] sub_ff;
    logic [7:0] tenths_ff;
    logic en_over;
    logic sub_end;

    assign en_over = detect_en && over;
    assign sub_end = (sub_ff == SW'(UNIT_CYC - 1));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sub_ff <= '0;
        else if (!en_over || sub_end)
            sub_ff <= '0;
        else
            sub_ff <= sub_ff + SW'(1);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tenths_ff <= 8'h00;
        else if (!en_over)
            tenths_ff <= 8'h00;
        else if (sub_end && tenths_ff != 8'hFF)
            tenths_ff <= tenths_ff + 8'h01;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarm_ff <= 1'b0;
            trip_ff <= 1'b0;
        end
        else
        begin
            alarm_ff <= en_over && ({tenths_ff, 1'b0} > {1'b0, detect_time});
            trip_ff <= en_over && (tenths_ff > detect_time);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_half_passed;
        en_over && ({tenths_ff, 1'b0} > {1'b0, detect_time});
    endsequence

    AST_OT_COUNT: assert property (en_over && !sub_end |=> sub_ff == $past(sub_ff) + SW'(1) || !$past(en_over))
        else $error("over-torque time not counting");
    AST_OT_ALARM: assert property (s_half_passed |=> alarm_ff)
        else $error("alarm missing past half detect time");
    AST_OT_TRIP: assert property (en_over && tenths_ff > detect_time |=> trip_ff ##0 alarm_ff)
        else $error("trip missing past detect time");
    AST_OT_CLEAR: assert property (!en_over |=> !alarm_ff && !trip_ff && tenths_ff == 8'h00)
        else $error("over-torque time or alarm not cleared");
endmodule
`default_nettype wire

/* saos_motor_model.sv */
// Behavioural model of the output stage, motor and bus sensors
`timescale 1ns/1ps
`default_nettype none
module saos_motor_model
    import saos_pkg::*;
#(
    parameter logic [15:0] OV_LIMIT = 16'h02BC
)
(
    // Drive state
    input wire saos_stat_t status,
    // Load and bus level set by the bench
    input wire logic [15:0] load_cur,
    input wire logic [15:0] bus_v,
    // Sensor readings
    output var saos_meas_t meas
);
    // No current flows while the output stage is off
    always_comb
    begin
        meas.output_current = status.drive_en ? load_cur : 16'h0000;
        meas.dc_bus_voltage = bus_v;
        meas.ov_threshold = OV_LIMIT;
    end
endmodule
`default_nettype wire

/* saos_supervisor_tb_top.sv */
// Self-checking testbench for the stall and over-torque supervisor
`timescale 1ns/1ps
`default_nettype none
module saos_supervisor_tb_top;
    import saos_pkg::*;
    logic clk;
    logic rst_n;
    saos_cfg_t cfg;
    saos_meas_t meas;
    saos_stat_t st;
    logic run_cmd;
    logic [15:0] cmd_freq;
    logic fault_clear;
    logic [15:0] load_cur;
    logic [15:0] bus_v;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    int n;

    saos_supervisor #(.UNIT_CYC(20)) dut (.clk(clk), .rst_n(rst_n), .cfg(cfg), .meas(meas), .run_cmd(run_cmd),
        .cmd_freq(cmd_freq), .accel_time(16'h0001), .decel_time(16'h0001), .fault_clear(fault_clear),
        .status_ff(st));
    saos_motor_model model (.status(st), .load_cur(load_cur), .bus_v(bus_v), .meas(meas));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fails++;
            $display("[ERR] run length expected below 30000 seen %0d", cyc);
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [15:0] fld(input int sel);
        case (sel)
            0: fld = st.freq;
            1: fld = 16'(st.ot_alarm);
            2: fld = 16'(st.fault);
            3: fld = st.comp_freq;
            default: fld = 16'(st.drive_en);
        endcase
    endfunction

    // Poll a status field on falling edges, bounded
    task automatic wst(input int sel, input logic [15:0] v, input int lim, output int k);
        k = 0;
        while (fld(sel) !== v && k < lim)
        begin
            @(negedge clk);
            k++;
        end
    endtask

    task automatic drive(input logic r, input logic [15:0] f, input logic [15:0] ld);
        @(posedge clk);
        run_cmd <= r;
        cmd_freq <= f;
        load_cur <= ld;
    endtask

    task automatic clear_fault();
        drive(1'b0, 16'h0000, 16'h0000);
        @(posedge clk);
        fault_clear <= 1'b1;
        @(posedge clk);
        fault_clear <= 1'b0;
        wst(2, 16'h0000, 4, n);
        chk("fault cleared", 16'h0000, fld(2));
    endtask

    task automatic t_reset();
        @(negedge clk);
        for (int i = 0; i < 5; i++)
            chk("status after reset", 16'h0000, fld(i));
        $display("test reset done");
    endtask

    task automatic t_ramp();
        drive(1'b1, 16'h000A, 16'h0384);
        repeat (300) @(negedge clk);
        chk("freq held in ramp", 16'h0000, fld(0));
        drive(1'b1, 16'h000A, 16'h01F4);
        wst(0, 16'h000A, 800, n);
        chk("freq after ramp", 16'h000A, fld(0));
        $display("test ramp done");
    endtask

    task automatic t_cstall();
        @(posedge clk);
        cfg.constant_speed_stall_level <= 8'h50;
        drive(1'b1, 16'h000A, 16'h0384);
        wst(0, 16'h0009, 200, n);
        chk("freq lowered", 16'h0009, fld(0));
        chk("stall flag", 16'h0001, 16'(st.stall_active));
        wst(0, 16'h0008, 200, n);
        chk("stall step cycles", 16'h0032, 16'(n));
        drive(1'b1, 16'h000A, 16'h01F4);
        wst(0, 16'h000A, 800, n);
        chk("freq restored", 16'h000A, fld(0));
        @(posedge clk);
        cfg.constant_speed_stall_level <= 8'h00;
        $display("test constant stall done");
    endtask

    task automatic t_ot();
        @(posedge clk);
        cfg.overtorque_detect_mode <= 2'h2;
        cfg.overtorque_detect_level <= 8'h32;
        cfg.overtorque_detect_time <= 8'h04;
        drive(1'b1, 16'h000A, 16'h0258);
        wst(1, 16'h0001, 120, n);
        chk("alarm raised", 16'h0001, fld(1));
        chk("alarm not before half", 16'h0001, 16'(n >= 40));
        chk("running with alarm", 16'h0001, fld(4));
        drive(1'b1, 16'h000A, 16'h0190);
        repeat (3) @(negedge clk);
        chk("alarm cleared", 16'h0000, fld(1));
        drive(1'b1, 16'h000A, 16'h0258);
        wst(2, 16'h0001, 150, n);
        chk("overtorque trip", 16'h0001, fld(2));
        chk("trip after full time", 16'h0001, 16'(n >= 80));
        chk("output stopped", 16'h0000, fld(4));
        clear_fault();
        $display("test overtorque done");
    endtask

    task automatic t_modes();
        @(posedge clk);
        cfg.overtorque_detect_mode <= 2'h0;
        drive(1'b1, 16'h000A, 16'h0258);
        repeat (400) @(negedge clk);
        chk("no alarm before speed", 16'h0000, fld(1));
        wst(1, 16'h0001, 300, n);
        chk("mode 0 alarm", 16'h0001, fld(1));
        chk("mode 0 runs on", 16'h0001, fld(4));
        drive(1'b1, 16'h000A, 16'h0190);
        @(posedge clk);
        cfg.overtorque_detect_mode <= 2'h1;
        drive(1'b1, 16'h000A, 16'h0258);
        wst(2, 16'h0001, 90, n);
        chk("mode 1 stops at alarm", 16'h0001, fld(2));
        clear_fault();
        @(posedge clk);
        cfg.overtorque_detect_mode <= 2'h3;
        drive(1'b1, 16'h000A, 16'h0258);
        wst(2, 16'h0001, 90, n);
        chk("mode 3 stops in ramp", 16'h0001, fld(2));
        clear_fault();
        $display("test modes done");
    endtask

    task automatic t_disable();
        @(posedge clk);
        cfg.overtorque_detect_mode <= 2'h2;
        cfg.overtorque_detect_level <= 8'h00;
        cfg.rampup_stall_level <= 8'h00;
        drive(1'b1, 16'h000A, 16'h0384);
        wst(0, 16'h000A, 800, n);
        chk("ramp without stall check", 16'h000A, fld(0));
        chk("no alarm at level 0", 16'h0000, fld(1));
        drive(1'b1, 16'h000A, 16'h044C);
        wst(2, 16'h0002, 6, n);
        chk("overcurrent trip", 16'h0002, fld(2));
        clear_fault();
        @(posedge clk);
        cfg.rampup_stall_level <= 8'h50;
        $display("test disable done");
    endtask

    task automatic t_slip_decel();
        drive(1'b1, 16'h0064, 16'h01F4);
        wst(0, 16'h0064, 5500, n);
        @(posedge clk);
        cfg.slip_compensation_gain <= 10'h3E8;
        repeat (3) @(negedge clk);
        chk("slip full gain", 16'h006E, fld(3));
        @(posedge clk);
        cfg.slip_compensation_gain <= 10'h1F4;
        repeat (3) @(negedge clk);
        chk("slip half gain", 16'h0069, fld(3));
        @(posedge clk);
        bus_v <= 16'h0320;
        drive(1'b0, 16'h0000, 16'h01F4);
        repeat (200) @(negedge clk);
        chk("decel held on high bus", 16'h0064, fld(0));
        @(posedge clk);
        bus_v <= 16'h0258;
        wst(0, 16'h0000, 5500, n);
        chk("decel resumed", 16'h0000, fld(0));
        $display("test slip and decel done");
    endtask

    initial
    begin
        cfg = CFG_DEFAULT;
        cfg.rated_motor_current = 16'h03E8;
        cfg.rampup_stall_level = 8'h50;
        cfg.stall_decel_time = 8'h01;
        rst_n = 1'b0;
        run_cmd = 1'b0;
        cmd_freq = 16'h0000;
        fault_clear = 1'b0;
        load_cur = 16'h0000;
        bus_v = 16'h01F4;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_ramp();
        t_cstall();
        t_ot();
        t_modes();
        t_disable();
        t_slip_decel();
        close_out();
    end
endmodule
`default_nettype wire
